// >>> design/cgo_hpf_chan.sv
// One channel of the first-order digital high-pass filter with bypass.
// Assumes in_valid is a one-cycle pulse per sample and k is held steady.
`timescale 1ns/100ps
module cgo_hpf_chan
(
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          reset,
  // Control.
  input  wire logic                          filter_on,
  input  wire logic [3:0]                    filter_k,
  // Sample in.
  input  wire logic                          in_valid,
  input  wire logic [cgo_pkg::SAMPLE_W-1:0]  in_sample,
  // Sample out.
  output logic                               out_valid,
  output logic [cgo_pkg::SAMPLE_W-1:0]       out_sample
);

  ////////////////////////////////////////////////////////////////////////////
  logic                             on_d_r;
  logic [cgo_pkg::SAMPLE_W-1:0]     xp_r;
  logic signed [cgo_pkg::HIST_W-1:0] yp_r;
  wire                              turn_on = filter_on & ~on_d_r;
  wire  [cgo_pkg::DATA_W-1:0]       recip   = cgo_pkg::hpf_recip(filter_k);

  // History is taken as zero in the cycle the filter turns on, so a sample in
  // that very cycle never sees stale terms.
  wire signed [16:0] xp_eff = turn_on ? 17'h00000 : 17'($signed(xp_r));
  wire signed [16:0] yp_eff = turn_on ? 17'h00000 : 17'(yp_r);
  wire signed [16:0] diff   = 17'($signed(in_sample)) - xp_eff + yp_eff;
  wire signed [33:0] prod   = diff * $signed({1'b0, recip});
  wire signed [17:0] y_full = prod[33:cgo_pkg::RECIP_FRAC];
  wire signed [cgo_pkg::HIST_W-1:0] y_hist =
    (y_full > 18'sh07FFF) ? 16'sh7FFF : (y_full < -18'sh08000) ? -16'sh8000 : y_full[15:0];

  // Output stage: filtered or bypassed sample, one cycle after the input.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      on_d_r     <= 1'b0;
      xp_r       <= '0;
      yp_r       <= '0;
      out_valid  <= 1'b0;
      out_sample <= '0;
    end
    else
    begin
      on_d_r    <= filter_on;
      out_valid <= in_valid;
      if (in_valid && filter_on)
      begin
        xp_r       <= in_sample;
        yp_r       <= y_hist;
        out_sample <= cgo_pkg::sat14(32'(y_full));
      end
      else
      begin
        if (turn_on)
        begin
          xp_r <= '0;
          yp_r <= '0;
        end
        if (in_valid)
          out_sample <= in_sample;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  hist_clear_on_a: assert property (filter_on && !on_d_r && !in_valid |=> xp_r == '0 && yp_r == '0)
    else $error("filter history not cleared when the filter turned on");
  bypass_pass_a: assert property (in_valid && !filter_on |=> out_valid && out_sample == $past(in_sample))
    else $error("bypassed sample differs from its input");
  first_step_a: assert property (in_valid && filter_on && !on_d_r |=>
                                 out_sample == cgo_pkg::sat14(32'((($past(17'($signed(in_sample))) *
                                   $signed({1'b0, $past(recip)})) >>> cgo_pkg::RECIP_FRAC))))
    else $error("first filtered sample does not follow the difference equation");

endmodule

// >>> design/cgo_pkg.sv
// Constants, field layouts, lookup functions and carrier types for the
// channel 5-8 gain, offset, high-pass and test-pattern block.
// Assumes a single 100 MHz clock and 14-bit two's-complement samples.
//
// Contract
// - With gain enabled, channel 8 is scaled by N x 0.2 dB, N from bits 15-11.
// - With offset enabled, channel 8 gets the signed 10-bit offset, one step per LSB.
// - With per-lane select, each lane 5-8 PRBS bit substitutes PRBS data.
// - With per-lane select, 3-bit codes choose the pattern on lanes 5 and 6.
// - Enabled filter computes y = 2^k/(2^k+1) x (x(n) - x(n-1) + y(n-1)).
// - Enable bit 0 low bypasses the filter on channels 5-8; high filters all four.
package cgo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int SAMPLE_W = 14;
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 16;
  localparam int LANES    = 4;
  localparam int HIST_W   = 16;
  localparam int PRBS_W   = 15;

  // Register offsets.
  localparam logic [ADDR_W-1:0] ADDR_GAIN_OFS = 6'h1F;
  localparam logic [ADDR_W-1:0] ADDR_OFS_COPY = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_PAT_HPF  = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL   = 6'h3E;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 6'h3F;
  localparam logic [DATA_W-1:0] REG_RESET     = 16'h0000;

  // Field positions.
  localparam int GAIN_MSB = 15;
  localparam int GAIN_LSB = 11;
  localparam int OFS_MSB  = 9;
  localparam int OFS_LSB  = 0;
  localparam int PRBS5_BIT = 15;
  localparam int PRBS6_BIT = 14;
  localparam int PRBS7_BIT = 13;
  localparam int PRBS8_BIT = 12;
  localparam int PAT5_MSB = 11;
  localparam int PAT5_LSB = 9;
  localparam int PAT6_MSB = 8;
  localparam int PAT6_LSB = 6;
  localparam int K_MSB    = 4;
  localparam int K_LSB    = 1;
  localparam int HPF_BIT  = 0;
  localparam int GBL_GAIN_BIT = 0;
  localparam int GBL_OFS_BIT  = 1;
  localparam int GBL_SEL_BIT  = 2;
  localparam int GBL_GRPA_BIT = 3;
  localparam int GBL_W        = 4;

  // Arithmetic scaling and limits.
  localparam int GAIN_FRAC  = 12;
  localparam int RECIP_FRAC = 16;
  localparam logic [3:0] K_MIN = 4'h2;
  localparam logic [3:0] K_MAX = 4'hA;
  localparam logic [SAMPLE_W-1:0] SAMP_MAX = 14'h1FFF;
  localparam logic [SAMPLE_W-1:0] SAMP_MIN = 14'h2000;
  localparam logic [SAMPLE_W-1:0] PAT_ONES_WORD = 14'h3FFF;
  localparam logic [SAMPLE_W-1:0] PAT_TOG_A     = 14'h1555;
  localparam logic [SAMPLE_W-1:0] PAT_TOG_B     = 14'h2AAA;
  localparam logic [PRBS_W-1:0]   PRBS_SEED     = 15'h7FFF;

  // Pattern codes for lanes 5 and 6.
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_ZEROS  = 3'h1;
  localparam logic [2:0] PAT_ONES   = 3'h2;
  localparam logic [2:0] PAT_TOGGLE = 3'h3;
  localparam logic [2:0] PAT_RAMP   = 3'h4;

  // One sample per lane with a common valid.
  typedef struct packed {
    logic                              valid;
    logic [LANES-1:0][SAMPLE_W-1:0]    data;
  } cgo_frame_s;

  ////////////////////////////////////////////////////////////////////////////
  // Linear gain of 10^(N x 0.01) in unsigned Q3.12 for 0.2 dB steps.
  function automatic logic [SAMPLE_W:0] gain_factor(input logic [4:0] n);
    logic [SAMPLE_W:0] g;
    g = 15'h1000;
    case (n)
      5'h00: g = 15'h1000;  5'h01: g = 15'h105F;  5'h02: g = 15'h10C1;  5'h03: g = 15'h1125;
      5'h04: g = 15'h118B;  5'h05: g = 15'h11F4;  5'h06: g = 15'h125F;  5'h07: g = 15'h12CC;
      5'h08: g = 15'h133D;  5'h09: g = 15'h13AF;  5'h0A: g = 15'h1425;  5'h0B: g = 15'h149D;
      5'h0C: g = 15'h1518;  5'h0D: g = 15'h1595;  5'h0E: g = 15'h1616;  5'h0F: g = 15'h169A;
      5'h10: g = 15'h1721;  5'h11: g = 15'h17AA;  5'h12: g = 15'h1838;  5'h13: g = 15'h18C8;
      5'h14: g = 15'h195C;  5'h15: g = 15'h19F3;  5'h16: g = 15'h1A8E;  5'h17: g = 15'h1B2C;
      5'h18: g = 15'h1BCE;  5'h19: g = 15'h1C74;  5'h1A: g = 15'h1D1E;  5'h1B: g = 15'h1DCB;
      5'h1C: g = 15'h1E7D;  5'h1D: g = 15'h1F33;  5'h1E: g = 15'h1FED;  5'h1F: g = 15'h20AB;
      default: g = 15'h1000;
    endcase
    return g;
  endfunction

  // 2^k/(2^k+1) in unsigned Q0.16; codes outside 2..10 clamp to the nearest end.
  function automatic logic [DATA_W-1:0] hpf_recip(input logic [3:0] k);
    logic [DATA_W-1:0] r;
    r = 16'hCCCD;
    case (k)
      4'h0, 4'h1, 4'h2: r = 16'hCCCD;
      4'h3: r = 16'hE38E;
      4'h4: r = 16'hF0F0;
      4'h5: r = 16'hF83E;
      4'h6: r = 16'hFC10;
      4'h7: r = 16'hFE04;
      4'h8: r = 16'hFF01;
      4'h9: r = 16'hFF80;
      default: r = 16'hFFC0;
    endcase
    return r;
  endfunction

  // Clamp a wide signed value into the 14-bit sample range.
  function automatic logic [SAMPLE_W-1:0] sat14(input logic signed [31:0] v);
    logic [SAMPLE_W-1:0] s;
    if (v > $signed({{18{SAMP_MAX[SAMPLE_W-1]}}, SAMP_MAX}))
      s = SAMP_MAX;
    else if (v < $signed({{18{SAMP_MIN[SAMPLE_W-1]}}, SAMP_MIN}))
      s = SAMP_MIN;
    else
      s = v[SAMPLE_W-1:0];
    return s;
  endfunction

endpackage

// >>> design/cgo_top.sv
// Channel 5-8 post-processing: channel 8 gain and offset, shared high-pass
// filter, and per-lane test-pattern substitution, with a plain register port.
// Assumes samples arrive synchronous to clk with a one-cycle valid per frame.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module cgo_top
(
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           reset,
  // Register port.
  input  wire logic [cgo_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [cgo_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [cgo_pkg::DATA_W-1:0]          reg_rdata,
  // Sample stream in, lanes 5 to 8 as indices 0 to 3.
  input  wire cgo_pkg::cgo_frame_s            in_frame,
  // Sample stream out, one per lane.
  output cgo_pkg::cgo_frame_s                 out_frame
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [cgo_pkg::DATA_W-1:0] gain_ofs_r;
  logic [cgo_pkg::DATA_W-1:0] ofs_copy_r;
  logic [cgo_pkg::DATA_W-1:0] pat_hpf_r;
  logic [cgo_pkg::GBL_W-1:0]  global_r;
  logic [cgo_pkg::SAMPLE_W-1:0] last_ch8_r;

  // Address decode for writes.
  wire wr_gain_ofs = reg_wr && (reg_addr == cgo_pkg::ADDR_GAIN_OFS);
  wire wr_ofs_copy = reg_wr && (reg_addr == cgo_pkg::ADDR_OFS_COPY);
  wire wr_pat_hpf  = reg_wr && (reg_addr == cgo_pkg::ADDR_PAT_HPF);
  wire wr_global   = reg_wr && (reg_addr == cgo_pkg::ADDR_GLOBAL);

  // Every bit of 0x1F to 0x21 is stored as written, reserved ones included; 0x3E keeps bits 3-0 only. The host keeps reserved bits zero.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gain_ofs_r <= cgo_pkg::REG_RESET;
      ofs_copy_r <= cgo_pkg::REG_RESET;
      pat_hpf_r  <= cgo_pkg::REG_RESET;
      global_r   <= '0;
    end
    else
    begin
      if (wr_gain_ofs)
        gain_ofs_r <= reg_wdata;
      if (wr_ofs_copy)
        ofs_copy_r <= reg_wdata;
      if (wr_pat_hpf)
        pat_hpf_r <= reg_wdata;
      if (wr_global)
        global_r <= reg_wdata[cgo_pkg::GBL_W-1:0];
    end
  end

  // Read selection; unmapped addresses read as zero.
  wire [cgo_pkg::DATA_W-1:0] rd_word =
    (reg_addr == cgo_pkg::ADDR_GAIN_OFS) ? gain_ofs_r :
    (reg_addr == cgo_pkg::ADDR_OFS_COPY) ? ofs_copy_r :
    (reg_addr == cgo_pkg::ADDR_PAT_HPF)  ? pat_hpf_r  :
    (reg_addr == cgo_pkg::ADDR_GLOBAL)   ? {12'h000, global_r} :
    (reg_addr == cgo_pkg::ADDR_STATUS)   ? {2'h0, last_ch8_r} : 16'h0000;

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_word : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields.
  wire       gain_apply_on        = global_r[cgo_pkg::GBL_GAIN_BIT];
  wire       offset_apply_on      = global_r[cgo_pkg::GBL_OFS_BIT];
  wire       per_lane_pattern_sel = global_r[cgo_pkg::GBL_SEL_BIT];
  wire       group_a_filter_on    = global_r[cgo_pkg::GBL_GRPA_BIT];
  wire [4:0] ch8_gain_steps       = gain_ofs_r[cgo_pkg::GAIN_MSB:cgo_pkg::GAIN_LSB];
  wire [9:0] ch8_offset_word      = gain_ofs_r[cgo_pkg::OFS_MSB:cgo_pkg::OFS_LSB];
  wire       lane5_prbs_on        = pat_hpf_r[cgo_pkg::PRBS5_BIT];
  wire       lane6_prbs_on        = pat_hpf_r[cgo_pkg::PRBS6_BIT];
  wire       lane7_prbs_on        = pat_hpf_r[cgo_pkg::PRBS7_BIT];
  wire       lane8_prbs_on        = pat_hpf_r[cgo_pkg::PRBS8_BIT];
  wire [2:0] lane5_pattern_code   = pat_hpf_r[cgo_pkg::PAT5_MSB:cgo_pkg::PAT5_LSB];
  wire [2:0] lane6_pattern_code   = pat_hpf_r[cgo_pkg::PAT6_MSB:cgo_pkg::PAT6_LSB];
  wire [3:0] group_b_filter_k     = pat_hpf_r[cgo_pkg::K_MSB:cgo_pkg::K_LSB];
  wire       group_b_filter_on    = pat_hpf_r[cgo_pkg::HPF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1: channel 8 gain, then offset, then saturation. Gain comes first so
  // the offset keeps its one-LSB step whatever gain is set.
  wire [cgo_pkg::SAMPLE_W-1:0] ch8_in   = in_frame.data[cgo_pkg::LANES-1];
  wire [cgo_pkg::SAMPLE_W:0]   gain_lin = cgo_pkg::gain_factor(ch8_gain_steps);
  wire signed [29:0] gain_prod  = $signed(ch8_in) * $signed({1'b0, gain_lin});
  wire signed [17:0] gain_out   = gain_apply_on ? gain_prod[29:cgo_pkg::GAIN_FRAC]
                                                : 18'($signed(ch8_in));
  wire signed [17:0] ofs_ext    = offset_apply_on ? 18'($signed(ch8_offset_word))
                                                  : 18'sh00000;
  wire signed [18:0] ch8_sum    = 19'(gain_out) + 19'(ofs_ext);
  wire [cgo_pkg::SAMPLE_W-1:0] ch8_corr = cgo_pkg::sat14(32'(ch8_sum));

  cgo_pkg::cgo_frame_s s1_frame_r;

  // Lanes 5 to 7 pass through this stage unchanged to keep lanes aligned.
  always_ff @(posedge clk)
  begin
    if (reset)
      s1_frame_r <= '0;
    else
    begin
      s1_frame_r.valid <= in_frame.valid;
      if (in_frame.valid)
      begin
        s1_frame_r.data[cgo_pkg::LANES-2:0] <= in_frame.data[cgo_pkg::LANES-2:0];
        s1_frame_r.data[cgo_pkg::LANES-1]   <= ch8_corr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 2: one filter per channel, all sharing the enable and k.
  logic [cgo_pkg::LANES-1:0]                    hpf_valid;
  logic [cgo_pkg::LANES-1:0][cgo_pkg::SAMPLE_W-1:0] hpf_data;

  for (genvar i = 0; i < cgo_pkg::LANES; i++)
  begin : g_hpf
    cgo_hpf_chan u_hpf
    (
      .clk        (clk),
      .reset      (reset),
      .filter_on  (group_b_filter_on),
      .filter_k   (group_b_filter_k),
      .in_valid   (s1_frame_r.valid),
      .in_sample  (s1_frame_r.data[i]),
      .out_valid  (hpf_valid[i]),
      .out_sample (hpf_data[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 3: pattern substitution. The PRBS and the ramp advance once per
  // output frame, so the pattern seen on the lanes does not depend on gaps.
  logic [cgo_pkg::PRBS_W-1:0]   prbs_r;
  logic [cgo_pkg::SAMPLE_W-1:0] ramp_r;
  logic                         tog_r;
  wire  frame_out = hpf_valid[0];
  wire  prbs_fb   = prbs_r[cgo_pkg::PRBS_W-1] ^ prbs_r[cgo_pkg::PRBS_W-2];
  wire [cgo_pkg::SAMPLE_W-1:0] prbs_word = prbs_r[cgo_pkg::SAMPLE_W-1:0];

  // Coded pattern for one lane; PRBS takes priority over the code.
  function automatic logic [cgo_pkg::SAMPLE_W-1:0] lane_word(
    input logic                         sel,
    input logic                         prbs_on,
    input logic [2:0]                   code,
    input logic [cgo_pkg::SAMPLE_W-1:0] normal,
    input logic [cgo_pkg::SAMPLE_W-1:0] prbs,
    input logic [cgo_pkg::SAMPLE_W-1:0] ramp,
    input logic                         tog);
    logic [cgo_pkg::SAMPLE_W-1:0] w;
    w = normal;
    if (sel && prbs_on)
      w = prbs;
    else if (sel)
    begin
      case (code)
        cgo_pkg::PAT_ZEROS:  w = '0;
        cgo_pkg::PAT_ONES:   w = cgo_pkg::PAT_ONES_WORD;
        cgo_pkg::PAT_TOGGLE: w = tog ? cgo_pkg::PAT_TOG_B : cgo_pkg::PAT_TOG_A;
        cgo_pkg::PAT_RAMP:   w = ramp;
        default:             w = normal;
      endcase
    end
    return w;
  endfunction

  // Lanes 5 and 6 take PRBS or a code; lanes 7 and 8 take PRBS only here.
  wire [cgo_pkg::SAMPLE_W-1:0] lane5_word = lane_word(per_lane_pattern_sel, lane5_prbs_on,
    lane5_pattern_code, hpf_data[0], prbs_word, ramp_r, tog_r);
  wire [cgo_pkg::SAMPLE_W-1:0] lane6_word = lane_word(per_lane_pattern_sel, lane6_prbs_on,
    lane6_pattern_code, hpf_data[1], prbs_word, ramp_r, tog_r);
  wire [cgo_pkg::SAMPLE_W-1:0] lane7_word = lane_word(per_lane_pattern_sel, lane7_prbs_on,
    cgo_pkg::PAT_NORMAL, hpf_data[2], prbs_word, ramp_r, tog_r);
  wire [cgo_pkg::SAMPLE_W-1:0] lane8_word = lane_word(per_lane_pattern_sel, lane8_prbs_on,
    cgo_pkg::PAT_NORMAL, hpf_data[3], prbs_word, ramp_r, tog_r);

  // Pattern generators.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prbs_r <= cgo_pkg::PRBS_SEED;
      ramp_r <= '0;
      tog_r  <= 1'b0;
    end
    else if (frame_out)
    begin
      prbs_r <= {prbs_r[cgo_pkg::PRBS_W-2:0], prbs_fb};
      ramp_r <= ramp_r + 14'h0001;
      tog_r  <= ~tog_r;
    end
  end

  // Output registers; the status word keeps the last lane 8 sample.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_frame  <= '0;
      last_ch8_r <= '0;
    end
    else
    begin
      out_frame.valid <= frame_out;
      if (frame_out)
      begin
        out_frame.data <= {lane8_word, lane7_word, lane6_word, lane5_word};
        last_ch8_r     <= lane8_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence plain_ch8_in;
    in_frame.valid && !gain_apply_on && !offset_apply_on;
  endsequence

  gain_unity_a: assert property (plain_ch8_in |=> s1_frame_r.data[3] == $past(ch8_in))
    else $error("channel 8 changed with gain and offset off");
  gain_step_a: assert property (in_frame.valid && gain_apply_on && !offset_apply_on && ch8_gain_steps == 5'h0A
                                && ch8_in == 14'h0400 |=> s1_frame_r.data[3] == 14'h0509)
    else $error("2 dB gain on 1024 did not give 1289");
  offset_add_a: assert property (in_frame.valid && !gain_apply_on && offset_apply_on |=>
                                 s1_frame_r.data[3] == cgo_pkg::sat14(32'($signed($past(ch8_in))) +
                                 32'($signed($past(ch8_offset_word)))))
    else $error("channel 8 offset not added");
  prbs_lane_a: assert property (frame_out && per_lane_pattern_sel && lane7_prbs_on |=>
                                out_frame.data[2] == $past(prbs_word))
    else $error("lane 7 does not carry the PRBS word");
  code_zero_a: assert property (frame_out && per_lane_pattern_sel && !lane6_prbs_on
                                && lane6_pattern_code == cgo_pkg::PAT_ZEROS |=> out_frame.data[1] == '0)
    else $error("lane 6 zero pattern not sent");
  no_pattern_a: assert property (frame_out && !per_lane_pattern_sel |=>
                                 out_frame.data == $past(hpf_data))
    else $error("pattern substituted without per-lane selection");
  bypass_path_a: assert property (plain_ch8_in ##0 !group_b_filter_on
                                  ##1 !group_b_filter_on ##1 !per_lane_pattern_sel |=>
                                  out_frame.data[0] == $past(in_frame.data[0], 3))
    else $error("bypassed lane 5 sample altered");
  read_gain_a: assert property (reg_rd && reg_addr == cgo_pkg::ADDR_GAIN_OFS |=> reg_rdata == $past(gain_ofs_r))
    else $error("gain register read back wrong");

  // The group 1-4 enable is only held for software; it steers nothing here.
  wire unused_grpa = group_a_filter_on;

endmodule

// >>> tb/cgo_host.sv
// Host model that programs and reads back the configuration registers.
// Assumes the block answers every read in the cycle after the strobe.
`timescale 1ns/100ps
module cgo_host
(
  // Clock.
  input  wire logic        clk,
  // Register port.
  output logic [5:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero.
  initial
  begin
    reg_addr  = 6'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Released write data is inverted so that a stale value cannot pass.
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Read data is taken just after the edge that accepted the strobe.
  task automatic read(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Reserved bits are forced low, both offset copies always agree and k below 2 is raised to 2.
  task automatic cfg(input logic [15:0] glob, input logic [15:0] r1f, input logic [15:0] r21);
    write(6'h3E, {12'h000, r21[0], glob[2:0]});
    write(6'h1F, r1f & 16'hFBFF);
    write(6'h20, {6'h00, r1f[9:0]});
    write(6'h21, (r21[4:1] < 4'h2) ? ((r21 & 16'hFFC1) | 16'h0004) : (r21 & 16'hFFDF));
  endtask
endmodule

// >>> tb/channel_gain_offset_hpf_pattern_tb_top.sv
// Self-checking bench for the channel 5-8 gain, offset, filter and pattern block.
// Assumes the host model drives the register port and the bench the sample stream.
`timescale 1ns/100ps
module channel_gain_offset_hpf_pattern_tb_top;
  typedef struct packed {
    logic [15:0] glob;
    logic [15:0] r1f;
    logic [15:0] r21;
    logic [13:0] x;
    logic [1:0]  lane;
    logic [13:0] y;
  } cgo_row_s;
  logic                clk;
  logic                reset;
  logic [5:0]          reg_addr;
  logic [15:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [15:0]         reg_rdata;
  logic [15:0]         rd;
  logic [14:0]         p;
  cgo_pkg::cgo_frame_s in_frame;
  cgo_pkg::cgo_frame_s out_frame;
  cgo_row_s            rows [12];
  int                  errors;
  int                  comparisons;

  cgo_top u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_frame(in_frame), .out_frame(out_frame));
  cgo_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Shared comparison, frame driver and closing report.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The wait is bounded so a lost frame ends the run instead of hanging it.
  task automatic send(input logic [13:0] x);
    int n;
    @(posedge clk);
    in_frame <= {1'b1, {4{x}}};
    @(posedge clk);
    in_frame.valid <= 1'b0;
    n = 0;
    while (out_frame.valid !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (out_frame.valid !== 1'b1)
    begin
      errors++;
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Table rows first, then PRBS, pattern, readback and turn-on cases, then reset and register cases by hand.
  initial
  begin
    reset = 1'b1;
    in_frame = '0;
    errors = 0;
    comparisons = 0;
    rows = '{'{16'h0000, 16'h0000, 16'h0000, 14'h0400, 2'h3, 14'h0400},
             '{16'h0001, 16'h5000, 16'h0000, 14'h0400, 2'h3, 14'h0509},
             '{16'h0002, 16'h03FF, 16'h0000, 14'h0400, 2'h3, 14'h03FF},
             '{16'h0003, 16'h5005, 16'h0000, 14'h0400, 2'h3, 14'h050E},
             '{16'h0001, 16'hF800, 16'h0000, 14'h1FFF, 2'h3, 14'h1FFF},
             '{16'h0000, 16'h0000, 16'h0005, 14'h03E8, 2'h0, 14'h0320},
             '{16'h0000, 16'h0000, 16'h0005, 14'h03E8, 2'h0, 14'h0280},
             '{16'h0000, 16'h0000, 16'h0000, 14'h03E8, 2'h0, 14'h03E8},
             '{16'h0000, 16'h0000, 16'h0015, 14'h03E8, 2'h0, 14'h03E7},
             '{16'h0004, 16'h0000, 16'h0280, 14'h0123, 2'h0, 14'h0000},
             '{16'h0004, 16'h0000, 16'h0280, 14'h0123, 2'h1, 14'h3FFF},
             '{16'h0000, 16'h0000, 16'h0280, 14'h0123, 2'h0, 14'h0123}};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      u_host.cfg(rows[i].glob, rows[i].r1f, rows[i].r21);
      send(rows[i].x);
      check("lane", {2'h0, out_frame.data[rows[i].lane]}, {2'h0, rows[i].y});
    end
    u_host.cfg(16'h0004, 16'h0000, 16'hF000);
    send(14'h0123);
    p = cgo_pkg::PRBS_SEED;
    repeat (12) p = {p[13:0], p[14] ^ p[13]};
    check("prbs5", {2'h0, out_frame.data[0]}, {2'h0, p[13:0]});
    check("prbs7", {2'h0, out_frame.data[2]}, {2'h0, p[13:0]});
    check("prbs8", {2'h0, out_frame.data[3]}, {2'h0, p[13:0]});
    u_host.cfg(16'h0004, 16'h0000, 16'h0700);
    send(14'h0123);
    check("toggle5", {2'h0, out_frame.data[0]}, 16'h2AAA);
    check("ramp6", {2'h0, out_frame.data[1]}, 16'h000D);
    check("lane8_plain", {2'h0, out_frame.data[3]}, 16'h0123);
    u_host.read(6'h3F, rd);
    check("status", rd, 16'h0123);
    u_host.read(6'h3E, rd);
    check("global", rd, 16'h0004);
    fork
      u_host.write(6'h21, 16'h0005);
      send(14'h03E8);
    join
    check("turn_on", {2'h0, out_frame.data[0]}, 16'h0320);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1;
    check("out_reset", out_frame.data[0], 16'h0000);
    for (int a = 31; a < 34; a++)
    begin
      u_host.read(6'(a), rd);
      check("reg_reset", rd, 16'h0000);
      u_host.write(6'(a), 16'h0295);
      u_host.read(6'(a), rd);
      check("reg_back", rd, 16'h0295);
    end
    u_host.read(6'h05, rd);
    check("unmapped", rd, 16'h0000);
    summarize();
  end
endmodule
